// ### hdl/drmc_ctrl.sv
// Host-side controller driving a 16K x 4 strobe DRAM bank
`timescale 1ns/1ns
module drmc_ctrl #(
  parameter int NUM_DEV     = 4,
  parameter int POWERUP_CYC = drmc_pkg::POWERUP_CYC,
  parameter int REFRESH_CYC = drmc_pkg::REFRESH_ROW_CYC
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        reset,
  // User request
  input  wire logic                        req_valid,
  output logic                             req_ready,
  input  wire logic                        req_write,
  input  wire logic [drmc_pkg::ROW_BITS-1:0] req_row,
  input  wire logic [drmc_pkg::COL_BITS-1:0] req_col,
  input  wire logic [$clog2(NUM_DEV)-1:0]  req_dev,
  input  wire logic [drmc_pkg::DATA_BITS-1:0] req_wdata,
  input  wire logic                        req_page_hold,
  // User answer
  output logic                             rd_valid,
  output logic [drmc_pkg::DATA_BITS-1:0]   rd_data,
  output logic                             init_done,
  // DRAM pins (strobes active low)
  output logic                             row_strobe_n,
  output logic [NUM_DEV-1:0]               col_strobe_n,
  output logic                             write_en_n,
  output logic                             out_en_n,
  output logic [drmc_pkg::ROW_BITS-1:0]    mux_address,
  input  wire logic [drmc_pkg::DATA_BITS-1:0] data_io_in,
  output logic [drmc_pkg::DATA_BITS-1:0]   data_io_out,
  output logic                             data_io_oe_n
);

  localparam int DW = drmc_pkg::DATA_BITS;
  localparam int RW = drmc_pkg::ROW_BITS;
  localparam int CW = drmc_pkg::COL_BITS;
  localparam int DVW = $clog2(NUM_DEV);
  localparam int TW = $clog2(POWERUP_CYC + 1) + 1;
  // Column low must cover both its own width and the row hold after the column falls
  localparam int COL_LOW_CYC =
    (drmc_pkg::COLUMN_LOW_CYC > drmc_pkg::ROW_HOLD_CYC) ?
    drmc_pkg::COLUMN_LOW_CYC : drmc_pkg::ROW_HOLD_CYC;
  localparam int ROW_LOW_MIN_CYC = drmc_pkg::COLUMN_HOLD_CYC;

  initial begin
    if (NUM_DEV < 2 || (NUM_DEV & (NUM_DEV - 1)) != 0)
      $error("drmc_ctrl NUM_DEV must be a power of two");
    if (POWERUP_CYC < 2 || REFRESH_CYC < 16)
      $error("drmc_ctrl counts too small");
  end

  typedef enum {
    S_POWERUP, S_INIT_LOW, S_INIT_HIGH, S_IDLE, S_ROW,
    S_COL_LOW, S_COL_HIGH, S_REF_LOW, S_PRECHARGE
  } drmc_fsm_t;

  typedef struct packed {
    drmc_fsm_t           fsm;
    logic [3:0]          init_cnt;
    logic [RW-1:0]       ref_row;
    logic                ref_pending;
    logic                row_open;
    logic [RW-1:0]       open_row;
    logic [DVW-1:0]      dev;
    logic [CW-1:0]       col;
    logic                wr;
    logic [DW-1:0]       wdata;
    logic                ras_n;
    logic [NUM_DEV-1:0]  cas_n;
    logic                we_n;
    logic                oe_n;
    logic [RW-1:0]       addr;
    logic                dq_oe_n;
    logic                rd_valid;
    logic [DW-1:0]       rd_data;
    logic                init_done;
    logic                tload;
    logic [TW-1:0]       tcount;
    logic                row_tload;
  } drmc_state_t;

  drmc_state_t st;
  drmc_state_t next_st;
  logic        tdone;
  logic        row_tdone;
  logic        ref_tick;

  // ==========================================================
  // Interval timers and refresh divider
  drmc_timer #(.WIDTH(TW)) u_phase_timer (
    .clk   (clk),
    .reset (reset),
    .load  (st.tload),
    .count (st.tcount),
    .done  (tdone)
  );

  // Tracks the least row-low time from the row strobe falling
  drmc_timer #(.WIDTH(TW)) u_row_timer (
    .clk   (clk),
    .reset (reset),
    .load  (st.row_tload),
    .count (TW'(ROW_LOW_MIN_CYC)),
    .done  (row_tdone)
  );

  drmc_refresh_tick #(.PERIOD(REFRESH_CYC)) u_ref_tick (
    .clk   (clk),
    .reset (reset),
    .tick  (ref_tick)
  );

  // A request is taken only in idle with no refresh waiting,
  // or in page mode on the open row
  assign req_ready = (st.fsm == S_IDLE && !st.ref_pending) ||
                     (st.fsm == S_ROW && tdone && !st.ref_pending &&
                      !st.row_open && req_row == st.open_row);

  // ==========================================================
  // Sequencer
  always_comb begin
    next_st = st;
    next_st.tload = 1'b0;
    next_st.tcount = '0;
    next_st.row_tload = 1'b0;
    next_st.rd_valid = 1'b0;
    // Set wins over clear: a tick in the cycle that clears pending keeps it set
    if (ref_tick) begin
      next_st.ref_pending = 1'b1;
    end
    unique case (st.fsm)
      // row high for the power-up wait
      S_POWERUP: begin
        if (tdone) begin
          next_st.fsm = S_INIT_LOW;
          next_st.ras_n = 1'b0;
          next_st.tload = 1'b1;
          next_st.tcount = TW'(ROW_LOW_MIN_CYC);
        end
      end
      // eight row cycles, column kept high
      S_INIT_LOW: begin
        if (tdone) begin
          next_st.ras_n = 1'b1;
          next_st.init_cnt = st.init_cnt + 1'b1;
          next_st.fsm = S_INIT_HIGH;
          next_st.tload = 1'b1;
          next_st.tcount = TW'(drmc_pkg::ROW_PRECHARGE_CYC);
        end
      end
      S_INIT_HIGH: begin
        if (tdone) begin
          if (st.init_cnt == 4'(drmc_pkg::INIT_CYCLES)) begin
            next_st.fsm = S_IDLE;
            next_st.init_done = 1'b1;
          end else begin
            next_st.fsm = S_INIT_LOW;
            next_st.ras_n = 1'b0;
            next_st.tload = 1'b1;
            next_st.tcount = TW'(ROW_LOW_MIN_CYC);
          end
        end
      end
      S_IDLE: begin
        if (st.ref_pending) begin
          // row-only refresh of the next row
          next_st.addr = st.ref_row;
          next_st.ras_n = 1'b0;
          next_st.fsm = S_REF_LOW;
          next_st.tload = 1'b1;
          next_st.tcount = TW'(ROW_LOW_MIN_CYC);
        end else if (req_valid) begin
          // row address stable as the row strobe falls
          next_st.addr = req_row;
          next_st.open_row = req_row;
          next_st.ras_n = 1'b0;
          next_st.row_tload = 1'b1;
          next_st.row_open = 1'b1;
          next_st.dev = req_dev;
          next_st.col = req_col;
          next_st.wr = req_write;
          next_st.wdata = req_wdata;
          next_st.fsm = S_ROW;
          next_st.tload = 1'b1;
          // column waits its delay after the row falls
          next_st.tcount = TW'(drmc_pkg::ROW_TO_COLUMN_CYC);
        end
      end
      S_ROW: begin
        if (tdone) begin
          // A page request is taken only once the last column is done
          if (req_ready && req_valid) begin
            next_st.dev = req_dev;
            next_st.col = req_col;
            next_st.wr = req_write;
            next_st.wdata = req_wdata;
            next_st.row_open = 1'b1;
          end
          if (next_st.row_open) begin
            // column bits ride on address lines one to six
            next_st.addr = {{(RW - CW - 1){1'b0}}, next_st.col, 1'b0};
            // early write, enable falls before column
            next_st.we_n = !next_st.wr;
            next_st.oe_n = next_st.wr;
            next_st.dq_oe_n = !next_st.wr;
            next_st.fsm = S_COL_LOW;
            next_st.row_open = 1'b0;
          end else if (!req_page_hold || st.ref_pending) begin
            next_st.fsm = S_PRECHARGE;
          end
        end
      end
      S_COL_LOW: begin
        if (st.cas_n == '1) begin
          // one row strobe spans every device
          // only the selected device sees a column strobe
          next_st.cas_n = ~(NUM_DEV'(1) << st.dev);
          next_st.tload = 1'b1;
          // column low and row hold after the column falls
          next_st.tcount = TW'(COL_LOW_CYC);
        end else if (tdone && row_tdone) begin
          // column stays low past the hold from row fall
          if (!st.wr) begin
            next_st.rd_data = data_io_in;
            next_st.rd_valid = 1'b1;
          end
          next_st.cas_n = '1;
          next_st.we_n = 1'b1;
          next_st.oe_n = 1'b1;
          next_st.dq_oe_n = 1'b1;
          next_st.fsm = S_COL_HIGH;
          next_st.tload = 1'b1;
          next_st.tcount = TW'(drmc_pkg::ROW_TO_COLUMN_CYC);
        end
      end
      // page mode keeps the row low for the next column
      S_COL_HIGH: begin
        if (tdone) begin
          next_st.fsm = S_ROW;
        end
      end
      S_REF_LOW: begin
        if (tdone) begin
          next_st.ref_row = st.ref_row + 1'b1;
          next_st.ref_pending = ref_tick;
          next_st.fsm = S_PRECHARGE;
        end
      end
      // column already high as the row rises
      // precharge before the next row fall
      S_PRECHARGE: begin
        if (st.ras_n == 1'b0) begin
          next_st.ras_n = 1'b1;
          next_st.tload = 1'b1;
          next_st.tcount = TW'(drmc_pkg::ROW_PRECHARGE_CYC);
        end else if (tdone) begin
          next_st.fsm = S_IDLE;
        end
      end
    endcase
  end

  // Reset starts the power-up wait at once
  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '0;
      st.fsm <= S_POWERUP;
      st.ras_n <= 1'b1;
      st.cas_n <= '1;
      st.we_n <= 1'b1;
      st.oe_n <= 1'b1;
      st.dq_oe_n <= 1'b1;
      st.tload <= 1'b1;
      st.tcount <= TW'(POWERUP_CYC);
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Pin and answer outputs, all registered
  assign row_strobe_n = st.ras_n;
  assign col_strobe_n = st.cas_n;
  assign write_en_n   = st.we_n;
  assign out_en_n     = st.oe_n;
  assign mux_address  = st.addr;
  assign data_io_out  = st.wdata;
  assign data_io_oe_n = st.dq_oe_n;
  assign rd_valid     = st.rd_valid;
  assign rd_data      = st.rd_data;
  assign init_done    = st.init_done;

endmodule

// ### hdl/drmc_pkg.sv
// Package of constants and types for the strobe DRAM controller
// Functional notes
// - Refresh every row within four milliseconds
// - Strobe all 256 rows, each refreshes row
// - Column strobe stays high during refresh
// - Page mode: hold row, strobe successive columns
// - 64 columns per page per device
// - Decode column strobe to selected device only
// - Row strobe high 100 us before init
// - Eight row-strobe cycles complete initialization
// - Row precharge at least 80 ns
// - Column strobe low at least 70 ns
// - Column falls 20 ns after row falls
// - Column low until 120 ns after row
// - Row rises 70 ns after column falls
// - Column high before next row fall
// - Write enable high reads, low writes
// - Row bits on row edge, column after
package drmc_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_MHZ = 20;
  localparam int ROW_PRECHARGE_TIME_NS = 80;
  localparam int COLUMN_LOW_TIME_NS = 70;
  localparam int ROW_TO_COLUMN_DELAY_NS = 20;
  localparam int COLUMN_HOLD_AFTER_ROW_NS = 120;
  localparam int ROW_HOLD_AFTER_COLUMN_NS = 70;
  localparam int POWERUP_WAIT_US = 100;
  localparam int REFRESH_PERIOD_US = 4000;
  localparam int ROW_COUNT = 256;
  localparam int INIT_CYCLES = 8;
  // Least times round up to whole cycles
  localparam int ROW_PRECHARGE_CYC =
    (ROW_PRECHARGE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int COLUMN_LOW_CYC =
    (COLUMN_LOW_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int ROW_TO_COLUMN_CYC =
    (ROW_TO_COLUMN_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int COLUMN_HOLD_CYC =
    (COLUMN_HOLD_AFTER_ROW_NS * CLK_MHZ + 999) / 1000;
  localparam int ROW_HOLD_CYC =
    (ROW_HOLD_AFTER_COLUMN_NS * CLK_MHZ + 999) / 1000;
  localparam int POWERUP_CYC = POWERUP_WAIT_US * CLK_MHZ;
  // Longest time rounds down; spread over all rows
  localparam int REFRESH_ROW_CYC =
    (REFRESH_PERIOD_US * CLK_MHZ) / ROW_COUNT;

  // ==========================================================
  // Address layout
  localparam int ROW_BITS = 8;
  localparam int COL_BITS = 6;
  localparam int DATA_BITS = 4;

  // Request kinds
  typedef enum logic [1:0] {
    DRMC_OP_READ,
    DRMC_OP_WRITE
  } drmc_op_t;

endpackage

// ### hdl/drmc_timer.sv
// Down counter that marks when a minimum interval has elapsed
`timescale 1ns/1ns
module drmc_timer #(
  parameter int WIDTH = 20
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Control
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] count,
  // Status
  output logic                  done
);

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } drmc_timer_state_t;

  drmc_timer_state_t st;
  drmc_timer_state_t next_st;

  initial begin
    if (WIDTH < 2) $error("drmc_timer WIDTH too small");
  end

  // Load wins over counting so back-to-back loads restart cleanly
  always_comb begin
    next_st = st;
    if (load) begin
      next_st.cnt = count;
    end else if (st.cnt != '0) begin
      next_st.cnt = st.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign done = (st.cnt == '0) && !load;

endmodule

// ### hdl/drmc_refresh_tick.sv
// Divider that raises a one-cycle refresh request per row interval
`timescale 1ns/1ns
module drmc_refresh_tick #(
  parameter int PERIOD = 312
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Enable pulse
  output logic      tick
);

  localparam int W = $clog2(PERIOD + 1);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } drmc_tick_state_t;

  drmc_tick_state_t st;
  drmc_tick_state_t next_st;

  initial begin
    if (PERIOD < 2) $error("drmc_refresh_tick PERIOD too small");
  end

  // Free-running divider; tick is registered
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt == W'(PERIOD - 1)) begin
      next_st.cnt = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;

endmodule

// ### sim/drmc_ctrl_sva.sv
// Pin timing checker for the strobe DRAM controller
`timescale 1ns/1ns
module drmc_ctrl_sva #(
  parameter int NUM_DEV     = 4,
  parameter int POWERUP_CYC = 2000,
  parameter int REFRESH_CYC = 312
) (
  // Clock and reset
  input wire logic                          clk,
  input wire logic                          reset,
  // DRAM pins
  input wire logic                          row_strobe_n,
  input wire logic [NUM_DEV-1:0]            col_strobe_n,
  input wire logic                          write_en_n,
  input wire logic                          out_en_n,
  input wire logic [drmc_pkg::ROW_BITS-1:0] mux_address,
  input wire logic                          data_io_oe_n,
  // Status
  input wire logic                          init_done
);
  // ==========================================================
  // Helper counters
  wire logic cas_n = &col_strobe_n;
  int hi_cnt;
  int lo_cnt;
  int gap_cnt;
  int rises;
  // High count spans reset on purpose: the strobe is held high there too
  always_ff @(posedge clk) begin
    hi_cnt <= row_strobe_n ? hi_cnt + 1 : 0;
    lo_cnt <= row_strobe_n ? 0 : lo_cnt + 1;
    gap_cnt <= $fell(row_strobe_n) ? 0 : gap_cnt + 1;
    rises <= reset ? 0 : rises + int'($rose(row_strobe_n));
  end

  // ==========================================================
  // Assertions
  default clocking dc @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_cas_fall;
    $fell(cas_n);
  endsequence
  sequence s_row_fall;
    $fell(row_strobe_n);
  endsequence
  AST_PRECHARGE:
    assert property ($rose(row_strobe_n) |-> row_strobe_n [*2])
    else $error("row precharge too short");
  AST_CAS_LOW:
    assert property (s_cas_fall |-> !cas_n [*2])
    else $error("column low pulse too short");
  AST_ROW_TO_COL:
    assert property (s_cas_fall |-> !row_strobe_n && lo_cnt >= 1)
    else $error("column fell too soon after row");
  AST_COL_HOLD:
    assert property ($rose(cas_n) |-> lo_cnt >= 3)
    else $error("column rose too soon after row fell");
  AST_ROW_HOLD:
    assert property (s_cas_fall |-> !row_strobe_n [*2])
    else $error("row rose too soon after column fell");
  AST_COL_PRECHARGE:
    assert property (s_row_fall |-> cas_n)
    else $error("column low at row fall");
  AST_POWERUP:
    assert property (s_row_fall and rises == 0 |-> hi_cnt >= POWERUP_CYC)
    else $error("power-up wait too short");
  AST_INIT_CYCLES:
    assert property ($rose(init_done) |->
                     rises + int'($rose(row_strobe_n)) >= 8)
    else $error("ready before eight row cycles");
  AST_NO_ACCESS_INIT:
    assert property (!init_done |-> cas_n)
    else $error("column strobe before init");
  AST_REFRESH_GAP:
    assert property (init_done |-> gap_cnt <= 2 * REFRESH_CYC)
    else $error("row strobe gap too long");
  AST_DRIVE_WRITE:
    assert property (!data_io_oe_n |-> !write_en_n && out_en_n)
    else $error("data driven outside a write");
  AST_EARLY_WRITE:
    assert property (s_cas_fall and !write_en_n |-> $past(write_en_n) == 1'b0)
    else $error("write enable late");
  AST_ADDR_STABLE:
    assert property (s_cas_fall |-> $stable(mux_address))
    else $error("address moved at column strobe");
  AST_ONE_DEVICE:
    assert property ($onehot0(~col_strobe_n))
    else $error("two column strobes low");
endmodule

// ### sim/drmc_dram_model.sv
// Behavioural 16K x 4 strobe DRAM on the far side of the controller
`timescale 1ns/1ns
module drmc_dram_model #(
  parameter int ACCESS_NS = 70
) (
  // Strobes and control
  input wire logic       row_strobe_n,
  input wire logic       col_strobe_n,
  input wire logic       write_en_n,
  input wire logic       out_en_n,
  // Address and data
  input wire logic [7:0] mux_address,
  input wire logic [3:0] data_in,
  output logic     [3:0] data_out,
  output logic           drive_n
);
  logic [3:0] mem [16384];
  time        stamp [256];
  bit         lost [256];
  logic [7:0] row;
  logic [5:0] col;
  logic       early = 1'b0;
  logic       ready = 1'b0;
  logic       on = 1'b0;
  // row latch; a stale row loses its data
  always @(negedge row_strobe_n) begin
    row = mux_address;
    if ($time - stamp[row] > 64'd4000000) lost[row] = 1'b1;
    stamp[row] = $time;
  end
  // column latch on A1..A6, early write
  always @(negedge col_strobe_n) begin
    col = mux_address[6:1];
    early = !write_en_n;
    ready = 1'b0;
    if (early) mem[{row, col}] = data_in;
    ready <= #ACCESS_NS 1'b1;
  end
  // output buffer, held until column or enable rises
  always @(row_strobe_n, col_strobe_n, out_en_n)
    if (col_strobe_n || out_en_n) on = 1'b0;
    else if (!row_strobe_n) on = 1'b1;
  assign drive_n = !on || early;
  // Before access time the pins show garbage, not the stored word
  assign data_out = ready ? mem[{row, col}] ^ {4{lost[row]}}
                          : ~mem[{row, col}];
endmodule

// ### sim/drmc_ctrl_bench.sv
// Self-checking bench for the DRAM controller with two device models
`timescale 1ns/1ns
module drmc_ctrl_bench;
  localparam int LIMIT = 95000;
  localparam int IDLE = 82000;
  logic       clk, reset, req_valid, req_ready, req_write, req_page_hold;
  logic       req_dev, rd_valid, init_done, row_strobe_n, write_en_n;
  logic       out_en_n, data_io_oe_n;
  logic [1:0] col_strobe_n, drv_n;
  logic [7:0] req_row, mux_address;
  logic [5:0] req_col;
  logic [3:0] req_wdata, rd_data, data_io_in, data_io_out, dq0, dq1;
  logic [3:0] idle_val = 4'h5;
  int         errors, comparisons, cycles, row_falls;

  // ==========================================================
  // Design, devices and shared data bus
  drmc_ctrl #(.NUM_DEV(2), .POWERUP_CYC(20), .REFRESH_CYC(40)) u_dut (
    .clk, .reset, .req_valid, .req_ready, .req_write, .req_row, .req_col,
    .req_dev, .req_wdata, .req_page_hold, .rd_valid, .rd_data, .init_done,
    .row_strobe_n, .col_strobe_n, .write_en_n, .out_en_n, .mux_address,
    .data_io_in, .data_io_out, .data_io_oe_n);
  drmc_dram_model #(.ACCESS_NS(70)) u_dev0 (.row_strobe_n,
    .col_strobe_n(col_strobe_n[0]), .write_en_n, .out_en_n, .mux_address,
    .data_in(data_io_in), .data_out(dq0), .drive_n(drv_n[0]));
  // Second device answers slowly
  drmc_dram_model #(.ACCESS_NS(140)) u_dev1 (.row_strobe_n,
    .col_strobe_n(col_strobe_n[1]), .write_en_n, .out_en_n, .mux_address,
    .data_in(data_io_in), .data_out(dq1), .drive_n(drv_n[1]));
  // Floating bus has no pull, so it shows a changing pattern
  assign data_io_in = !drv_n[0] ? dq0 : !drv_n[1] ? dq1 :
                      !data_io_oe_n ? data_io_out : idle_val;

  // ==========================================================
  // Clock, watchdog and row strobe count
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    idle_val <= ~idle_val;
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors++;
      summarize();
    end
  end
  always @(negedge row_strobe_n) row_falls++;

  // ==========================================================
  // Compare and access tasks
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_data(input logic [3:0] got, input logic [3:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // One request held until taken; reads wait for the answer pulse
  task automatic access(input logic wr, input logic dev,
      input logic [7:0] row, input logic [5:0] col, input logic [3:0] wd,
      input logic hold, output logic [3:0] got);
    int n;
    @(negedge clk);
    req_valid = 1'b1;
    req_write = wr;
    req_dev = dev;
    req_row = row;
    req_col = col;
    req_wdata = wd;
    req_page_hold = hold;
    n = 0;
    while (req_ready !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    req_valid = 1'b0;
    n = 0;
    while (!wr && rd_valid !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    got = rd_data;
  endtask
  // Both devices, top rows and columns; reads compare the stored word
  task automatic rw_table(input logic wr);
    logic [3:0] got;
    for (int i = 0; i < 8; i++) begin
      access(wr, i[0], 8'hff - 8'(i), 6'h3f - 6'(i), 4'(i + 5), 1'b0, got);
      if (!wr) check_data(got, 4'(i + 5));
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_init();
    int n;
    check_val({init_done, req_ready}, 0);
    check_val({row_strobe_n, col_strobe_n, write_en_n, out_en_n,
               data_io_oe_n}, 'h3f);
    n = 0;
    while (init_done !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    check_val(init_done, 1);
    check_val(row_falls, 8);
  endtask
  // Columns 0 and 1 differ only in the lowest column bit
  task automatic t_page();
    logic [3:0] got;
    for (int c = 0; c < 4; c++)
      access(1'b1, 1'b0, 8'h05, 6'(c), 4'h9 ^ 4'(c), c < 3, got);
    for (int c = 0; c < 4; c++) begin
      access(1'b0, 1'b0, 8'h05, 6'(c), 4'h0, c < 3, got);
      check_data(got, 4'h9 ^ 4'(c));
    end
  endtask
  // Long idle past the retention time, refresh only, then reread
  task automatic t_refresh();
    int start;
    int busy;
    start = row_falls;
    busy = 0;
    repeat (IDLE) begin
      @(negedge clk);
      if (col_strobe_n !== 2'b11 || drv_n !== 2'b11) busy++;
    end
    check_val(busy, 0);
    check_val(row_falls - start >= IDLE / 40 - 1, 1);
    rw_table(1'b0);
  endtask

  task automatic summarize();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    {reset, req_valid, req_write, req_page_hold, req_dev} = 5'h10;
    {req_row, req_col, req_wdata} = 18'h0;
    repeat (10) @(negedge clk);
    reset = 1'b0;
    t_init();
    rw_table(1'b1);
    rw_table(1'b0);
    t_page();
    t_refresh();
    summarize();
  end
endmodule

bind drmc_ctrl drmc_ctrl_sva #(.NUM_DEV(NUM_DEV), .POWERUP_CYC(POWERUP_CYC),
  .REFRESH_CYC(REFRESH_CYC)) u_sva (.clk, .reset, .row_strobe_n,
  .col_strobe_n, .write_en_n, .out_en_n, .mux_address, .data_io_oe_n,
  .init_done);
